// *** verilog/host_port_pkg.sv ***
// constants and types shared by the host parallel port
package host_port_pkg;
    localparam int unsigned CHANNELS   = 8;
    localparam int unsigned FIFO_DEPTH = 64;
    localparam int unsigned ADDR_W     = 9;
    localparam int unsigned DATA_W     = 16;
    localparam logic [1:0]  LANE_LO    = 2'h1;
    localparam logic [1:0]  LANE_HI    = 2'h2;
    localparam logic [1:0]  LANE_BOTH  = 2'h3;
    localparam logic [1:0]  LANE_NONE  = 2'h0;
    localparam logic [15:0] DATA_RST   = 16'h0000;
    localparam logic [8:0]  ADDR_RST   = 9'h000;

    typedef enum logic [2:0] {
        BUS_STROBE_PAIR = 3'b001,
        BUS_DATA_STROBE = 3'b010,
        BUS_MULTIPLEXED = 3'b100
    } bus_style_e;
endpackage : host_port_pkg

// *** verilog/host_parallel_bus_port.sv ***
// host parallel bus port: register access and per-channel fifo access
`timescale 1ns/1ps
module host_parallel_bus_port
    import host_port_pkg::*;
#(
    parameter int unsigned CH    = CHANNELS,
    parameter int unsigned DEPTH = FIFO_DEPTH
) (
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    input  wire logic [ADDR_W-1:0]    reg_addr_in,
    input  wire logic [DATA_W-1:0]    host_data_in,
    output logic      [DATA_W-1:0]    host_data_out,
    output logic      [1:0]           host_data_oe_n,
    input  wire logic                 read_or_data_strobe_n,
    input  wire logic                 write_or_direction,
    input  wire logic                 chip_select_n,
    input  wire logic                 addr_latch,
    input  wire logic                 port_width,
    input  wire logic                 byte_lane_enable_n,
    input  wire logic [CH-1:0]        dma_ack_per_channel_n,
    input  wire logic                 irq_ack_strobe_n,
    output logic                      transfer_ack_out,
    output logic                      transfer_ack_oe_n,
    output logic                      reg_rd,
    output logic                      reg_wr,
    output logic      [ADDR_W-1:0]    reg_index,
    output logic      [DATA_W-1:0]    reg_wdata,
    output logic      [1:0]           reg_lanes,
    input  wire logic [DATA_W-1:0]    reg_rdata,
    input  wire logic [CH-1:0]        rx_push,
    input  wire logic [CH-1:0][7:0]   rx_byte,
    output logic      [CH-1:0]        rx_ready,
    input  wire logic [CH-1:0]        tx_pop,
    output logic      [CH-1:0][7:0]   tx_byte,
    output logic      [CH-1:0]        tx_valid
);
    localparam int unsigned AW = $clog2(DEPTH);

    // bus style detection
    logic        ale_q;
    logic        ale_seen;
    logic        ale_toggled;
    bus_style_e  style;
    logic [ADDR_W-1:0] addr_latched;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ale_q       <= 1'b0;
            ale_seen    <= 1'b0;
            ale_toggled <= 1'b0;
        end else begin
            ale_q    <= addr_latch;
            ale_seen <= 1'b1;
            if (ale_seen && ale_q != addr_latch) begin
                ale_toggled <= 1'b1;
            end
        end
    end

    always_comb begin
        if (ale_toggled) style = BUS_MULTIPLEXED;
        else if (addr_latch) style = BUS_DATA_STROBE;
        else style = BUS_STROBE_PAIR;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            addr_latched <= ADDR_RST;
        end else if (ale_seen && ale_q && !addr_latch) begin
            addr_latched <= reg_addr_in;
        end
    end

    // strobe decoding
    logic strobe_act;
    logic is_read;
    logic dma_sel;
    logic reg_sel;
    logic cyc_live;
    logic cyc_q;
    logic start;
    logic [$clog2(CH)-1:0] dma_ch;
    logic [1:0] lanes;

    always_comb begin
        unique case (style)
            BUS_DATA_STROBE: begin
                strobe_act = !read_or_data_strobe_n;
                is_read    = write_or_direction;
            end
            BUS_STROBE_PAIR, BUS_MULTIPLEXED: begin
                strobe_act = !read_or_data_strobe_n || !write_or_direction;
                is_read    = !read_or_data_strobe_n;
            end
            default: begin
                strobe_act = 1'b0;
                is_read    = 1'b0;
            end
        endcase
    end

    always_comb begin
        dma_ch = '0;
        for (int i = CH - 1; i >= 0; i--) begin
            if (!dma_ack_per_channel_n[i]) dma_ch = i[$clog2(CH)-1:0];
        end
    end

    assign dma_sel  = !(&dma_ack_per_channel_n);
    assign reg_sel  = !chip_select_n && !dma_sel && irq_ack_strobe_n;
    assign cyc_live = strobe_act && (reg_sel || dma_sel);
    assign start    = cyc_live && !cyc_q;

    always_comb begin
        if (!port_width) lanes = LANE_LO;
        // a0 is taken from reg_index, so multiplexed style uses the latched address
        else if (style == BUS_DATA_STROBE) lanes = {!reg_index[0], !byte_lane_enable_n};
        else lanes = {!byte_lane_enable_n, !reg_index[0]};
    end

    // register side strobes
    assign reg_index = (style == BUS_MULTIPLEXED) ? addr_latched : reg_addr_in;
    assign reg_rd    = start && reg_sel && is_read;
    assign reg_wr    = start && reg_sel && !is_read;
    assign reg_wdata = host_data_in;
    assign reg_lanes = lanes;

    // fifo access from the host
    logic       host_push;
    logic       host_pop;
    logic [1:0] nbytes;
    logic [7:0] push_b0;
    logic [7:0] push_b1;
    logic [7:0]       rx_h0  [CH];
    logic [7:0]       rx_h1  [CH];
    logic [CH-1:0]    pop_ok;

    assign host_push = start && dma_sel && !is_read;
    assign host_pop  = start && dma_sel && is_read;
    assign nbytes    = (lanes == LANE_BOTH) ? 2'd2 : ((lanes == LANE_NONE) ? 2'd0 : 2'd1);
    assign push_b0   = lanes[0] ? host_data_in[7:0] : host_data_in[15:8];
    assign push_b1   = host_data_in[15:8];

    for (genvar c = 0; c < CH; c++) begin : chan
        logic [7:0]  txm [DEPTH];
        logic [7:0]  rxm [DEPTH];
        logic [AW-1:0] twp, trp, rwp, rrp;
        logic [AW:0] tcnt, rcnt;
        logic        hp, hq, sp, sq;
        logic [AW:0] tin, tout, rin, rout;

        assign hp   = host_push && dma_ch == c && (tcnt + {{(AW-1){1'b0}}, nbytes}) <= (AW+1)'(DEPTH);
        assign sq   = tx_pop[c] && tcnt != '0;
        assign tin  = hp ? {{(AW-1){1'b0}}, nbytes} : '0;
        assign tout = sq ? (AW+1)'(1) : '0;
        assign hq   = host_pop && dma_ch == c && rcnt >= {{(AW-1){1'b0}}, nbytes};
        assign sp   = rx_push[c] && rcnt != (AW+1)'(DEPTH);
        assign rin  = sp ? (AW+1)'(1) : '0;
        assign rout = hq ? {{(AW-1){1'b0}}, nbytes} : '0;

        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                twp  <= '0;
                trp  <= '0;
                tcnt <= '0;
            end else begin
                if (hp) begin
                    txm[twp] <= push_b0;
                    if (nbytes == 2'd2) txm[twp + AW'(1)] <= push_b1;
                    twp <= twp + AW'(nbytes);
                end
                if (sq) trp <= trp + AW'(1);
                tcnt <= tcnt + tin - tout;
            end
        end

        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                rwp  <= '0;
                rrp  <= '0;
                rcnt <= '0;
            end else begin
                if (sp) begin
                    rxm[rwp] <= rx_byte[c];
                    rwp      <= rwp + AW'(1);
                end
                if (hq) rrp <= rrp + AW'(nbytes);
                rcnt <= rcnt + rin - rout;
            end
        end

        assign tx_byte[c]  = txm[trp];
        assign tx_valid[c] = tcnt != '0;
        assign rx_ready[c] = rcnt != (AW+1)'(DEPTH);
        assign rx_h0[c]    = rxm[rrp];
        assign rx_h1[c]    = rxm[rrp + AW'(1)];
        assign pop_ok[c]   = hq;
    end

    // read data, lane drivers and acknowledge
    logic [DATA_W-1:0] rd_word;
    always_comb begin
        if (!dma_sel) rd_word = reg_rdata;
        else if (!pop_ok[dma_ch]) rd_word = DATA_RST;
        else if (lanes == LANE_BOTH) rd_word = {rx_h1[dma_ch], rx_h0[dma_ch]};
        else if (lanes == LANE_HI) rd_word = {rx_h0[dma_ch], 8'h00};
        else rd_word = {8'h00, rx_h0[dma_ch]};
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cyc_q <= 1'b0;
        end else begin
            cyc_q <= cyc_live;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            host_data_out  <= DATA_RST;
            host_data_oe_n <= 2'h3;
        end else if (start && is_read) begin
            host_data_out  <= rd_word;
            host_data_oe_n <= ~lanes;
        end else if (!cyc_live) begin
            host_data_oe_n <= 2'h3;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            transfer_ack_oe_n <= 1'b1;
        end else if (start) begin
            transfer_ack_oe_n <= 1'b0;
        end else if (!cyc_live) begin
            transfer_ack_oe_n <= 1'b1;
        end
    end
    assign transfer_ack_out = 1'b0;

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    ack_follows_start_a: assert property (start |=> !transfer_ack_oe_n)
        else $error("acknowledge not raised after start");
    ack_release_a: assert property (!cyc_live |=> transfer_ack_oe_n)
        else $error("acknowledge held after cycle end");
    narrow_high_float_a: assert property (!port_width && start |=> host_data_oe_n[1])
        else $error("high lane driven in narrow mode");
    reg_read_pulse_a: assert property (reg_rd |-> reg_sel && is_read && !cyc_q)
        else $error("register read outside selected read start");
    reg_write_once_a: assert property (reg_wr |=> !reg_wr)
        else $error("register write repeated in one cycle");
    select_gates_dma_a: assert property (dma_sel |-> !reg_rd && !reg_wr)
        else $error("register strobe during dma cycle");
    toggle_mux_a: assert property (ale_seen && $changed(addr_latch) |=> style == BUS_MULTIPLEXED)
        else $error("toggling latch pin did not pick multiplexed style");
    latch_fall_a: assert property (ale_seen && $fell(addr_latch) |=> addr_latched == $past(reg_addr_in))
        else $error("address not captured on latch fall");
    dma_push_count_a: assert property (host_push && dma_ch == 0 && chan[0].tcnt == '0 && !tx_pop[0]
        && nbytes == 2'd2 |=> chan[0].tcnt == (AW+1)'(2))
        else $error("word push did not add two bytes");
    read_lane_drive_a: assert property (start && is_read |=> host_data_oe_n == ~$past(lanes))
        else $error("read lanes differ from decode");

    word_dma_read_c: cover property (host_pop && lanes == LANE_BOTH);
    byte_reg_write_c: cover property (reg_wr && port_width && lanes == LANE_HI);
    mux_style_read_c: cover property (style == BUS_MULTIPLEXED && reg_rd);
    data_strobe_write_c: cover property (style == BUS_DATA_STROBE && reg_wr);
endmodule : host_parallel_bus_port

// *** test/reg_map_model.sv ***
// register map seen behind the host port
`timescale 1ns/1ps
module reg_map_model
    import host_port_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              reg_wr,
    input  wire logic [ADDR_W-1:0] reg_index,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic [1:0]        reg_lanes,
    output logic      [DATA_W-1:0] reg_rdata
);
    logic [DATA_W-1:0] mem [512];
    initial for (int i = 0; i < 512; i++) mem[i] = 16'h0000;
    always @(posedge sys_clk) begin
        if (reg_wr && reg_lanes[0]) mem[reg_index][7:0] <= reg_wdata[7:0];
        if (reg_wr && reg_lanes[1]) mem[reg_index][15:8] <= reg_wdata[15:8];
    end
    assign reg_rdata = mem[reg_index];
endmodule : reg_map_model

// *** test/testbench.sv ***
// self-checking bench for the host parallel port
`timescale 1ns/1ps
module testbench;
    import host_port_pkg::*;
    logic sys_clk = 0, resetn = 0, read_or_data_strobe_n = 1, write_or_direction = 1, chip_select_n = 1;
    logic addr_latch = 0, port_width = 1, byte_lane_enable_n = 1, irq_ack_strobe_n = 1;
    logic [8:0] reg_addr_in = 0, reg_index;
    logic [15:0] host_data_in = 0, host_data_out, reg_wdata, reg_rdata;
    logic [1:0] host_data_oe_n, reg_lanes;
    logic [7:0] dma_ack_per_channel_n = 8'hff, rx_push = 0, tx_pop = 0, rx_ready, tx_valid;
    logic [7:0][7:0] rx_byte = 0, tx_byte;
    logic transfer_ack_out, transfer_ack_oe_n, reg_rd, reg_wr;
    int n_mismatch, n_tests;
    bit ds, mux;
    logic [15:0] ref_mem [512];
    logic [7:0] txq [8][$];
    logic [7:0] rxq [8][$];
    host_parallel_bus_port dut (.sys_clk, .resetn, .reg_addr_in, .host_data_in, .host_data_out, .host_data_oe_n,
        .read_or_data_strobe_n, .write_or_direction, .chip_select_n, .addr_latch, .port_width, .byte_lane_enable_n,
        .dma_ack_per_channel_n, .irq_ack_strobe_n, .transfer_ack_out, .transfer_ack_oe_n, .reg_rd, .reg_wr,
        .reg_index, .reg_wdata, .reg_lanes, .reg_rdata, .rx_push, .rx_byte, .rx_ready, .tx_pop, .tx_byte, .tx_valid);
    reg_map_model far (.sys_clk, .reg_wr, .reg_index, .reg_wdata, .reg_lanes, .reg_rdata);
    always #2.5 sys_clk = ~sys_clk;
    int n_rd, n_wr;
    always @(posedge sys_clk) begin
        n_rd <= n_rd + int'(reg_rd === 1'b1);
        n_wr <= n_wr + int'(reg_wr === 1'b1);
    end
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task complete_run;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : complete_run
    task do_reset(input bit style);
        @(negedge sys_clk) resetn = 0;
        ds = style;
        mux = 0;
        addr_latch = style;
        repeat (16) @(negedge sys_clk);
        resetn = 1;
        repeat (2) @(negedge sys_clk);
    endtask : do_reset
    function logic [1:0] lanes_of(input logic a0, input logic ble_n);
        if (!port_width) return 2'h1;
        return ds ? {!a0, !ble_n} : {!ble_n, !a0};
    endfunction : lanes_of
    task wait_ack(input logic lvl);
        int i;
        for (i = 0; i < 20 && transfer_ack_oe_n !== lvl; i++) @(negedge sys_clk);
        if (i == 20) begin
            n_mismatch++;
            complete_run();
        end
    endtask : wait_ack
    task bus(input bit dma, input int ch, input bit wr, input logic [8:0] a, input logic [15:0] d,
             input logic ble_n, output logic [15:0] q, output logic [1:0] oe);
        int rd0, wr0;
        rd0 = n_rd;
        wr0 = n_wr;
        reg_addr_in = a;
        if (mux) begin
            addr_latch = 1;
            @(negedge sys_clk) addr_latch = 0;
            @(negedge sys_clk) reg_addr_in = d[8:0];
        end
        host_data_in = d;
        byte_lane_enable_n = ble_n;
        chip_select_n = dma ? 1'($urandom) : 1'b0;
        if (dma) dma_ack_per_channel_n[ch] = 0;
        read_or_data_strobe_n = ds ? 1'b0 : wr;
        write_or_direction = !wr;
        wait_ack(0);
        q = host_data_out;
        oe = host_data_oe_n;
        check("ack_level", {15'h0, transfer_ack_out}, 16'h0);
        @(negedge sys_clk);
        read_or_data_strobe_n = 1;
        write_or_direction = 1;
        chip_select_n = 1;
        dma_ack_per_channel_n = 8'hff;
        wait_ack(1);
        check("oe_idle", {14'h0, host_data_oe_n}, 16'h3);
        check("reg_rd", 16'(n_rd - rd0), {15'h0, 1'(!dma && !wr)});
        check("reg_wr", 16'(n_wr - wr0), {15'h0, 1'(!dma && wr)});
    endtask : bus
    task reg_access(input bit wr, input logic [8:0] a, input logic [15:0] d, input logic ble_n);
        logic [15:0] q, m;
        logic [1:0] oe, ln;
        ln = lanes_of(a[0], ble_n);
        m = {{8{ln[1]}}, {8{ln[0]}}};
        bus(0, 0, wr, a, d, ble_n, q, oe);
        if (wr) ref_mem[a] = (ref_mem[a] & ~m) | (d & m);
        else begin
            check("reg_read", q & m, ref_mem[a] & m);
            check("read_oe", {14'h0, oe}, {14'h0, ~ln});
        end
    endtask : reg_access
    task reg_loop(input int n, input string name);
        logic [8:0] a;
        logic b;
        repeat (n) begin
            a = 9'($urandom);
            b = 1'($urandom);
            if (a[0] && b) b = 0;
            reg_access(1, a, 16'($urandom), b);
            reg_access(0, a, 16'h0000, 1'($urandom) & !a[0]);
        end
        $display("test %s done", name);
    endtask : reg_loop
    task refused(input logic cs_n, input logic irq_n);
        chip_select_n = cs_n;
        irq_ack_strobe_n = irq_n;
        reg_addr_in = 9'h0a5;
        host_data_in = 16'($urandom);
        write_or_direction = 0;
        repeat (4) @(negedge sys_clk) check("no_ack", {15'h0, transfer_ack_oe_n}, 16'h1);
        write_or_direction = 1;
        chip_select_n = 1;
        irq_ack_strobe_n = 1;
        @(negedge sys_clk) reg_access(0, 9'h0a5, 16'h0000, 0);
    endtask : refused
    task fifo_test(input int ch);
        logic [15:0] q, d;
        logic [1:0] oe;
        repeat (3) begin
            d = 16'($urandom);
            bus(1, ch, 1, 9'($urandom) & 9'h1fe, d, 0, q, oe);
            txq[ch].push_back(d[7:0]);
            txq[ch].push_back(d[15:8]);
        end
        d = 16'($urandom);
        bus(1, ch, 1, 9'h001, d, 0, q, oe);
        txq[ch].push_back(d[15:8]);
        while (txq[ch].size() > 0) begin
            check("tx_valid", {15'h0, tx_valid[ch]}, 16'h1);
            check("tx_byte", {8'h0, tx_byte[ch]}, {8'h0, txq[ch].pop_front()});
            tx_pop[ch] = 1;
            @(negedge sys_clk) tx_pop[ch] = 0;
        end
        check("tx_empty", {15'h0, tx_valid[ch]}, 16'h0);
        repeat (64) begin
            rx_byte[ch] = 8'($urandom);
            rx_push[ch] = 1;
            rxq[ch].push_back(rx_byte[ch]);
            @(negedge sys_clk);
        end
        rx_push[ch] = 0;
        check("rx_full", {15'h0, rx_ready[ch]}, 16'h0);
        repeat (32) begin
            bus(1, ch, 0, 9'($urandom) & 9'h1fe, 16'h0000, 0, q, oe);
            d[7:0] = rxq[ch].pop_front();
            d[15:8] = rxq[ch].pop_front();
            check("rx_word", q, d);
            check("rx_oe", {14'h0, oe}, 16'h0);
        end
        check("rx_room", {15'h0, rx_ready[ch]}, 16'h1);
        $display("test fifo done");
    endtask : fifo_test
    initial begin
        for (int i = 0; i < 512; i++) ref_mem[i] = 16'h0000;
        void'($urandom(32'h040f));
        do_reset(0);
        reg_loop(20, "strobe_pair");
        refused(1, 1);
        refused(0, 0);
        fifo_test(int'($urandom % 8));
        port_width = 0;
        reg_loop(6, "narrow");
        port_width = 1;
        do_reset(1);
        reg_loop(12, "data_strobe");
        do_reset(0);
        mux = 1;
        reg_loop(12, "multiplexed");
        complete_run();
    end
endmodule : testbench
